// [rtl/gpio_ctl.sv]
// AHB-Lite register block for GPIO pin ownership, hold pin and pin level readback
`timescale 1ns/1ps
//Contract
// - Field 15:14 equal 11 hands GPIO12-14 to GPIO registers; resets 00.
// - Bit 13 is active-low hold pin direction; 1 input, resets 1.
// - Bit 12 value drives hold pin when output; resets 0.
// - Bit 11 reads sampled hold pin level; writes ignored.
// - Bit 9 set releases LED high drive to high impedance; resets 0.
// - Two-bit fields hand GPIO8-11 to GPIO registers with code 11.
// - Level readback bits 0-14 show GPIO0-14; bit 15 reserved.
// - Registers survive soft reset and are shared by all ports.
// - Per-pin output enable selects driving output value or input.
module gpio_ctl (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// GPIO8 to GPIO14 pins, three signals each; GPIO0-7 levels are read only here
	input  wire logic [14:0] gpio_in,
	output logic      [14:8] gpio_out,
	output logic      [14:8] gpio_oe,
	// Low-power hold pin
	input  wire logic        low_power_hold_pin_in,
	output logic             low_power_hold_pin_out,
	output logic             low_power_hold_pin_oe,
	// LED drive option for the LED block
	output logic             led_tristate
);
	typedef struct packed {
		logic        wr_pend;
		logic [9:0]  wr_addr;
		logic [15:0] ctrl2;
		logic [14:0] pin_out;
		logic [14:0] pin_oe;
		logic [31:0] rdata;
	} ctl_state_t;

	ctl_state_t state_reg;
	ctl_state_t state_next;
	logic [14:8] owned;
	logic [15:0] level_word;
	logic        take;

	pin_sync_if sync_bus ();

	assign sync_bus.raw = {low_power_hold_pin_in, gpio_in};

	pin_sync u_pin_sync (
		.hclk    (hclk),
		.hresetn (hresetn),
		.pins    (sync_bus)
	);

	// Bit 15 reserved reads zero
	assign level_word = {1'b0, sync_bus.synced[14:0]};

	// Ownership per pin; GPIO12-14 share one field
	genvar i;
	generate
		for (i = 8; i < 15; i++) begin : g_own
			if (i >= 12) begin : g_high
				assign owned[i] = state_reg.ctrl2[gpio_ctl_pkg::HIGH_OWN_MSB:gpio_ctl_pkg::HIGH_OWN_LSB]
					== gpio_ctl_pkg::OWN_GPIO_CODE;
			end else begin : g_low
				assign owned[i] = state_reg.ctrl2[2*(i-8)+1:2*(i-8)] == gpio_ctl_pkg::OWN_GPIO_CODE;
			end
			// Reserved codes leave the pin undriven, the safe choice for an unknown board
			assign gpio_oe[i]  = owned[i] & state_reg.pin_oe[i];
			assign gpio_out[i] = state_reg.pin_out[i];
		end
	endgenerate

	assign take = hsel & hready & (htrans == gpio_ctl_pkg::HTRANS_NONSEQ);

	always_comb begin
		state_next         = state_reg;
		state_next.wr_pend = 1'b0;
		if (state_reg.wr_pend) begin
			case (state_reg.wr_addr)
				gpio_ctl_pkg::CTRL2_ADDR: begin
					// Read-only bit 11 and bit 8 keep their value; reserved bit 10 takes the written value
					state_next.ctrl2 = (hwdata[15:0] & gpio_ctl_pkg::CTRL2_WMASK)
						| (state_reg.ctrl2 & ~gpio_ctl_pkg::CTRL2_WMASK);
				end
				gpio_ctl_pkg::PIN_DRIVE_ADDR: begin
					state_next.pin_out = hwdata[14:0];
					state_next.pin_oe  = hwdata[30:16];
				end
				default: begin
					state_next.ctrl2 = state_reg.ctrl2;
				end
			endcase
		end
		if (take) begin
			state_next.wr_pend = hwrite;
			state_next.wr_addr = haddr[9:0];
			case (haddr[9:0])
				gpio_ctl_pkg::CTRL2_ADDR: begin
					state_next.rdata = {16'h0000, state_reg.ctrl2[15:12],
						sync_bus.synced[15], state_reg.ctrl2[10:0]};
				end
				gpio_ctl_pkg::LEVEL_ADDR: begin
					state_next.rdata = {16'h0000, level_word};
				end
				gpio_ctl_pkg::PIN_DRIVE_ADDR: begin
					state_next.rdata = {1'b0, state_reg.pin_oe, 1'b0, state_reg.pin_out};
				end
				default: begin
					state_next.rdata = 32'h0000_0000;
				end
			endcase
		end
	end

	// Only hresetn clears these; there is no soft reset path by design
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg         <= '0;
			state_reg.ctrl2   <= gpio_ctl_pkg::CTRL2_RESET;
			state_reg.pin_out <= gpio_ctl_pkg::PIN_OUT_RESET;
			state_reg.pin_oe  <= gpio_ctl_pkg::PIN_OE_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	assign hrdata    = state_reg.rdata;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	assign low_power_hold_pin_oe  = ~state_reg.ctrl2[gpio_ctl_pkg::HOLD_DIR_N_BIT];
	assign low_power_hold_pin_out = state_reg.ctrl2[gpio_ctl_pkg::HOLD_OUT_BIT];
	assign led_tristate           = state_reg.ctrl2[gpio_ctl_pkg::LED_TRI_BIT];
endmodule : gpio_ctl

// [rtl/gpio_ctl_pkg.sv]
// Register offsets, field positions and reset values for the GPIO control block
package gpio_ctl_pkg;
	// Printed offsets 0x0e and 0x0f are not multiples of four: they are indices
	localparam logic [7:0]  CTRL2_INDEX       = 8'h0e;
	localparam logic [7:0]  LEVEL_INDEX       = 8'h0f;
	localparam logic [9:0]  CTRL2_ADDR        = {CTRL2_INDEX, 2'h0};
	localparam logic [9:0]  LEVEL_ADDR        = {LEVEL_INDEX, 2'h0};
	// Own register for the GPIO output and output-enable words used by handed-over pins
	localparam logic [9:0]  PIN_DRIVE_ADDR    = 10'h040;
	localparam int          HIGH_OWN_MSB      = 15;
	localparam int          HIGH_OWN_LSB      = 14;
	localparam int          HOLD_DIR_N_BIT    = 13;
	localparam int          HOLD_OUT_BIT      = 12;
	localparam int          HOLD_IN_BIT       = 11;
	localparam int          RSVD10_BIT        = 10;
	localparam int          LED_TRI_BIT       = 9;
	localparam int          GPIO_COUNT        = 15;
	localparam logic [1:0]  OWN_GPIO_CODE     = 2'h3;
	localparam logic [15:0] CTRL2_RESET       = 16'h2400;
	localparam logic [15:0] CTRL2_WMASK       = 16'hf6ff;
	localparam logic [14:0] PIN_OUT_RESET     = 15'h0000;
	localparam logic [14:0] PIN_OE_RESET      = 15'h0000;
	localparam logic [1:0]  HTRANS_NONSEQ     = 2'h2;
endpackage : gpio_ctl_pkg

// [rtl/pin_sync.sv]
// Two-stage synchroniser for the GPIO and hold pin levels
`timescale 1ns/1ps
module pin_sync (
	// Clock and reset
	input  wire logic hclk,
	input  wire logic hresetn,
	// Pin levels
	pin_sync_if.sync  pins
);
	typedef struct packed {
		logic [15:0] meta;
		logic [15:0] stable;
	} sync_state_t;

	sync_state_t state_reg;
	sync_state_t state_next;

	// Only the second stage is read outside
	always_comb begin
		state_next        = state_reg;
		state_next.meta   = pins.raw;
		state_next.stable = state_reg.meta;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign pins.synced = state_reg.stable;
endmodule : pin_sync

// [rtl/pin_sync_if.sv]
// Carrier between the pin synchroniser and the register block
`timescale 1ns/1ps
interface pin_sync_if;
	logic [15:0] raw;
	logic [15:0] synced;
	modport sync (input raw, output synced);
	modport user (output raw, input synced);
endinterface : pin_sync_if

// [sim/board_pins.sv]
// Board side of the GPIO and hold pins
`timescale 1ns/1ps
module board_pins (
	// Outside levels
	input  wire logic [14:0] ext,
	input  wire logic        ext_hold,
	// Device drive
	input  wire logic [14:8] out,
	input  wire logic [14:8] oe,
	input  wire logic        hold_out,
	input  wire logic        hold_oe,
	// Levels at the device
	output logic      [14:0] lvl,
	output logic             hold_lvl
);
	// A driven pin reads back the device's own value
	assign lvl      = {(oe & out) | (~oe & ext[14:8]), ext[7:0]};
	assign hold_lvl = hold_oe ? hold_out : ext_hold;
endmodule : board_pins

// [sim/gpio_ctl_asserts.sv]
// Port checks for the GPIO control block
`timescale 1ns/1ps
module gpio_ctl_asserts (
	// Bus
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic [31:0] hwdata,
	input wire logic [31:0] hrdata,
	// Pins
	input wire logic [14:0] gpio_in,
	input wire logic [14:8] gpio_oe,
	input wire logic        low_power_hold_pin_in,
	input wire logic        low_power_hold_pin_out,
	input wire logic        low_power_hold_pin_oe,
	input wire logic        led_tristate
);
	logic [2:0] ph_reg;
	wire        take = hsel && hready && htrans == gpio_ctl_pkg::HTRANS_NONSEQ;
	wire        c2   = haddr[9:0] == gpio_ctl_pkg::CTRL2_ADDR;
	// Data phase flags: control write, control read, level read
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn) ph_reg <= 3'h0;
		else ph_reg <= {3{take}} & {hwrite && c2, !hwrite && c2, !hwrite && haddr[9:0] == gpio_ctl_pkg::LEVEL_ADDR};
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_hold_dir: assert property (ph_reg[2] |=> low_power_hold_pin_oe == !$past(hwdata[13])) else $error("hold dir");
	a_hold_value: assert property (ph_reg[2] |=> low_power_hold_pin_out == $past(hwdata[12])) else $error("hold out");
	a_led_release: assert property (ph_reg[2] |=> led_tristate == $past(hwdata[9])) else $error("led mode");
	a_high_owner: assert property (ph_reg[2] && hwdata[15:14] != 2'h3 |=> gpio_oe[14:12] == 3'h0) else $error("own hi");
	a_low_owner: assert property (ph_reg[2] && hwdata[1:0] != 2'h3 |=> !gpio_oe[8]) else $error("own lo");
	a_reset_state: assert property ($rose(hresetn) |-> !low_power_hold_pin_oe && !low_power_hold_pin_out
		&& !led_tristate && gpio_oe == 7'h0) else $error("reset pins");
	a_level_read: assert property (ph_reg[0] |-> hrdata == {17'h0, $past(gpio_in, 3)}) else $error("level");
	a_hold_sense: assert property (ph_reg[1] |-> hrdata[11] == $past(low_power_hold_pin_in, 3)) else $error("sense");
endmodule : gpio_ctl_asserts

// [sim/gpio_pin_control_and_input_bench.sv]
// Self-checking bench for the GPIO control block
`timescale 1ns/1ps
module gpio_pin_control_and_input_bench;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [14:0] ext = 15'h0;
	logic        ext_hold = 1'b0;
	logic [31:0] rd;
	wire  [31:0] hrdata;
	wire         hready, hresp, hold_out, hold_oe, hold_lvl, led_tristate;
	wire  [14:8] gpio_out, gpio_oe;
	wire  [14:0] lvl;
	int          err_total = 0;
	int          n_checks = 0;
	always #10 hclk = ~hclk;
	gpio_ctl u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
		.gpio_in(lvl), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .low_power_hold_pin_in(hold_lvl),
		.low_power_hold_pin_out(hold_out), .low_power_hold_pin_oe(hold_oe), .led_tristate(led_tristate));
	board_pins u_pins (.ext(ext), .ext_hold(ext_hold), .out(gpio_out), .oe(gpio_oe), .hold_out(hold_out),
		.hold_oe(hold_oe), .lvl(lvl), .hold_lvl(hold_lvl));
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task bus(input logic w, input logic [9:0] a, input logic [31:0] d);
		// The host is taken to have selected the general-purpose page already
		hsel   <= 1'b1;
		haddr  <= {22'h0, a};
		htrans <= gpio_ctl_pkg::HTRANS_NONSEQ;
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask : bus
	task t_hold;
		bus(1'b0, gpio_ctl_pkg::CTRL2_ADDR, 32'h0);
		chk(rd, 32'h2400);
		bus(1'b1, gpio_ctl_pkg::CTRL2_ADDR, 32'h1000);
		// Readback lags the pin by the synchroniser
		repeat (4) @(posedge hclk);
		bus(1'b0, gpio_ctl_pkg::CTRL2_ADDR, 32'h0);
		chk(rd, 32'h1800);
		ext_hold <= 1'b1;
		bus(1'b1, gpio_ctl_pkg::CTRL2_ADDR, 32'h2b00);
		repeat (4) @(posedge hclk);
		bus(1'b0, gpio_ctl_pkg::CTRL2_ADDR, 32'h0);
		chk(rd, 32'h2a00);
		chk(32'({hold_oe, led_tristate}), 32'h1);
		$display("hold pin done");
	endtask : t_hold
	task t_own;
		bus(1'b1, gpio_ctl_pkg::PIN_DRIVE_ADDR, 32'h7f00_5500);
		for (int c = 0; c < 4; c++) begin
			bus(1'b1, gpio_ctl_pkg::CTRL2_ADDR, {16'h0, 2'(c), 6'h20, {4{2'(c)}}});
			@(negedge hclk);
			chk(32'(gpio_oe), c == 3 ? 32'h7f : 32'h0);
		end
		chk(32'(gpio_out), 32'h55);
		bus(1'b1, gpio_ctl_pkg::PIN_DRIVE_ADDR, 32'h5500_5500);
		bus(1'b1, gpio_ctl_pkg::CTRL2_ADDR, 32'h20c3);
		@(negedge hclk);
		chk(32'(gpio_oe), 32'h01);
		$display("ownership done");
	endtask : t_own
	task t_level;
		@(posedge hclk);
		ext <= 15'h4a5a;
		repeat (4) @(posedge hclk);
		bus(1'b0, gpio_ctl_pkg::LEVEL_ADDR, 32'h0);
		chk(rd, 32'h4b5a);
		bus(1'b0, 10'h3fc, 32'h0);
		chk(rd, 32'h0);
		chk(32'(hresp), 32'h0);
		$display("levels done");
	endtask : t_level
	task print_verdict;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : print_verdict
	initial begin
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		t_hold();
		t_own();
		t_level();
		print_verdict();
	end
	initial begin
		#50us;
		err_total++;
		print_verdict();
	end
endmodule : gpio_pin_control_and_input_bench
bind gpio_ctl gpio_ctl_asserts u_chk (.*);
